// >>> core/uart_mode_status_control.sv
`timescale 1ns/1ps
// Functional notes
// - IR codec on: receive pin is IR input, transmit pin drives IR output.
// - IR codec works only with sixteen-times oversampling selected.
// - Disabled: pins released, logic frozen; enabled: pins per usage field.
// - Stop-in-idle set halts the module while the device idles.
// - Request pin mode: set is simplex, clear is flow control.
// - Usage field picks transmit, receive, request, clear and clock pins.
// - Wake: falling receive edge in sleep interrupts, next rise clears bit.
// - Loopback bit feeds transmit line back into the receiver.
// - Auto-rate measures a 55h sync character, then clears its bit.
// - Receive polarity set makes receive idle low.
// - High-speed bit: four ticks per bit, else sixteen.
// - Format field: 9N, 8 odd, 8 even or 8N.
// - Stop select: two stop bits when set, else one.
// - Transmit interrupt: any load, load emptying buffer, or all done.
// - Transmit polarity sets idle level, reversed with IR codec on.
// - Break: start, twelve zeros, stop; hardware then clears the bit.
// - Clearing transmit enable aborts, flushes buffer, releases pin.
// - Buffer-full flag reads one only when four characters wait.
// - Shifter-empty flag reads one when shifter and buffer are empty.
// - Receive interrupt: every character, or at three, or at four held.
// - Unimplemented mode and status bits ignore writes and read zero.
module uart_mode_status_control
  import uart_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  // Device power state
  input wire logic idle_mode,
  input wire logic sleep_mode,
  // Serial pins
  input wire logic serial_in_pin,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe,
  input wire logic clear_to_send_pin_n,
  output logic request_to_send_pin_n_o,
  output logic request_to_send_pin_oe,
  output logic baud_clock_out_pin_o,
  output logic baud_clock_out_pin_oe,
  // Events
  output logic tx_irq,
  output logic rx_irq,
  output logic wake_irq
);
  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] stat;
    logic [15:0] div;
    logic div_wr;
    logic [3:0][8:0] txq;
    logic [2:0] tx_cnt;
    logic [1:0] tx_rd;
    logic [1:0] tx_wr;
    tx_state_t tx_st;
    logic [14:0] tx_sh;
    logic [3:0] tx_left;
    logic [3:0] tx_sub;
    logic tx_brk;
    logic [3:0][8:0] rxq;
    logic [2:0] rx_cnt;
    logic [1:0] rx_rd;
    logic [1:0] rx_wr;
    rx_state_t rx_st;
    logic [8:0] rx_sh;
    logic [3:0] rx_idx;
    logic [3:0] rx_sub;
    logic rx_prev;
    logic [3:0] ir_hold;
    logic [23:0] abd_cnt;
    logic [2:0] abd_edges;
    logic wake_armed;
    logic [15:0] rdata;
    logic tx_o;
    logic tx_oe;
    logic rts_n;
    logic rts_oe;
    logic bclk_o;
    logic bclk_oe;
    logic tx_irq;
    logic rx_irq;
    logic wake_irq;
  } uart_state_t;

  uart_state_t s_r, s_nxt;
  logic run, tick, bclk;
  logic [3:0] os_end;
  logic ir_act, pin_in, rx_bit, tx_line, cts_ok;
  logic tx_push, tx_load, tx_done, rx_push, rx_pop, abd_fin;
  logic [18:0] frame;
  logic [1:0] pd;

  // ==========================================================
  // Oversample clock
  baud_tick_gen u_baud (
    .clk(clk),
    .reset_n(reset_n),
    .run(run),
    .restart(s_r.div_wr),
    .divisor(s_r.div),
    .tick(tick),
    .clk_out(bclk)
  );

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    tx_load = 1'b0;
    tx_done = 1'b0;
    rx_push = 1'b0;
    abd_fin = 1'b0;
    frame = '0;
    s_nxt.div_wr = 1'b0;
    s_nxt.tx_irq = 1'b0;
    s_nxt.rx_irq = 1'b0;
    s_nxt.wake_irq = 1'b0;
    s_nxt.rdata = 16'h0000;
    pd = s_r.mode[M_PD +: 2];
    run = s_r.mode[M_EN] && !(idle_mode && s_r.mode[M_SIDL]);
    os_end = os_last(s_r.mode[M_HIGH_SPEED_SELECT]);
    ir_act = s_r.mode[M_INFRARED_CODEC_ENABLE] && !s_r.mode[M_HIGH_SPEED_SELECT];
    pin_in = serial_in_pin ^ s_r.mode[M_RECEIVE_POLARITY_BIT];
    tx_line = (s_r.tx_st == TX_SHIFT) ? s_r.tx_sh[0] : 1'b1;
    if (s_r.mode[M_LPBK]) begin
      rx_bit = tx_line;
    end else if (ir_act) begin
      rx_bit = pin_in && (s_r.ir_hold == 4'h0);
    end else begin
      rx_bit = pin_in;
    end
    cts_ok = (s_r.mode[M_USE +: 2] != USE_FLOW) || !clear_to_send_pin_n;
    tx_push = wr_en && (addr == ADDR_TXD) && (s_r.tx_cnt != FIFO_DEPTH);
    rx_pop = rd_en && (addr == ADDR_RXD) && (s_r.rx_cnt != 3'h0);

    // Transmit buffer and shifter
    if (tx_push) begin
      s_nxt.txq[s_r.tx_wr] = wdata[8:0];
      s_nxt.tx_wr = s_r.tx_wr + 2'h1;
    end
    if (run && s_r.stat[S_TXEN] && s_r.tx_st == TX_IDLE &&
        s_r.tx_cnt != 3'h0 && cts_ok) begin
      tx_load = 1'b1;
      frame = build_frame(s_r.txq[s_r.tx_rd], pd, s_r.mode[M_STOP_BIT_SELECT],
        s_r.stat[S_BRK]);
      s_nxt.tx_sh = frame[14:0];
      s_nxt.tx_left = frame[18:15];
      s_nxt.tx_sub = 4'h0;
      s_nxt.tx_brk = s_r.stat[S_BRK];
      s_nxt.tx_st = TX_SHIFT;
      s_nxt.tx_rd = s_r.tx_rd + 2'h1;
    end else if (run && s_r.tx_st == TX_SHIFT && tick) begin
      if (s_r.tx_sub == os_end) begin
        s_nxt.tx_sub = 4'h0;
        s_nxt.tx_sh = {1'b1, s_r.tx_sh[14:1]};
        s_nxt.tx_left = s_r.tx_left - 4'h1;
        if (s_r.tx_left == 4'h1) begin
          s_nxt.tx_st = TX_IDLE;
          tx_done = 1'b1;
          if (s_r.tx_brk) begin
            s_nxt.stat[S_BRK] = 1'b0;
          end
          s_nxt.tx_brk = 1'b0;
        end
      end else begin
        s_nxt.tx_sub = s_r.tx_sub + 4'h1;
      end
    end
    s_nxt.tx_cnt = s_r.tx_cnt + {2'h0, tx_push} - {2'h0, tx_load};
    case ({s_r.stat[S_TXIS1], s_r.stat[S_TXIS0]})
      TXI_ANY: s_nxt.tx_irq = tx_load;
      TXI_EMPTY: s_nxt.tx_irq = tx_load && s_nxt.tx_cnt == 3'h0;
      TXI_DONE: s_nxt.tx_irq = tx_done && s_r.tx_cnt == 3'h0;
      default: s_nxt.tx_irq = 1'b0;
    endcase

    // Receiver, sampled mid-bit
    if (run && tick) begin
      if (!pin_in) begin
        s_nxt.ir_hold = os_end;
      end else if (s_r.ir_hold != 4'h0) begin
        s_nxt.ir_hold = s_r.ir_hold - 4'h1;
      end
      case (s_r.rx_st)
        RX_IDLE: begin
          if (!rx_bit && !s_r.mode[M_AUTO_RATE_ENABLE]) begin
            s_nxt.rx_st = RX_START;
            s_nxt.rx_sub = 4'h0;
          end
        end
        RX_START: begin
          if (s_r.rx_sub == (os_end >> 1)) begin
            s_nxt.rx_sub = 4'h0;
            s_nxt.rx_idx = 4'h0;
            s_nxt.rx_st = rx_bit ? RX_IDLE : RX_DATA;
          end else begin
            s_nxt.rx_sub = s_r.rx_sub + 4'h1;
          end
        end
        RX_DATA: begin
          if (s_r.rx_sub == os_end) begin
            s_nxt.rx_sub = 4'h0;
            s_nxt.rx_sh[s_r.rx_idx] = rx_bit;
            s_nxt.rx_idx = s_r.rx_idx + 4'h1;
            if (s_r.rx_idx == ((pd == PD_8N) ? 4'h7 : 4'h8)) begin
              s_nxt.rx_st = RX_STOP;
            end
          end else begin
            s_nxt.rx_sub = s_r.rx_sub + 4'h1;
          end
        end
        RX_STOP: begin
          if (s_r.rx_sub == os_end) begin
            s_nxt.rx_sub = 4'h0;
            s_nxt.rx_st = RX_IDLE;
            // A full buffer drops the new character
            rx_push = (s_r.rx_cnt != FIFO_DEPTH);
          end else begin
            s_nxt.rx_sub = s_r.rx_sub + 4'h1;
          end
        end
        default: s_nxt.rx_st = RX_IDLE;
      endcase
    end
    if (rx_push) begin
      s_nxt.rxq[s_r.rx_wr] = (pd == PD_9N) ? s_r.rx_sh :
        {1'b0, s_r.rx_sh[7:0]};
      s_nxt.rx_wr = s_r.rx_wr + 2'h1;
    end
    if (rx_pop) begin
      s_nxt.rx_rd = s_r.rx_rd + 2'h1;
    end
    s_nxt.rx_cnt = s_r.rx_cnt + {2'h0, rx_push} - {2'h0, rx_pop};
    case (s_r.stat[S_RXIS +: 2])
      RXI_4: s_nxt.rx_irq = rx_push && s_nxt.rx_cnt == 3'h4;
      RXI_3: s_nxt.rx_irq = rx_push && s_nxt.rx_cnt == 3'h3;
      default: s_nxt.rx_irq = rx_push;
    endcase

    // Rate measurement over eight bit times of the sync
    if (run && s_r.mode[M_AUTO_RATE_ENABLE]) begin
      if (s_r.abd_edges != 3'h0) begin
        s_nxt.abd_cnt = s_r.abd_cnt + 24'h000001;
      end
      if (s_r.rx_prev && !rx_bit) begin
        if (s_r.abd_edges == 3'h0) begin
          s_nxt.abd_cnt = 24'h000000;
        end
        if (s_r.abd_edges == SYNC_EDGES - 3'h1) begin
          abd_fin = 1'b1;
          s_nxt.abd_edges = 3'h0;
          s_nxt.mode[M_AUTO_RATE_ENABLE] = 1'b0;
          s_nxt.div_wr = 1'b1;
          s_nxt.div = 16'(s_r.abd_cnt >> (s_r.mode[M_HIGH_SPEED_SELECT] ?
            ABD_SH_HS : ABD_SH_STD)) - 16'h0001;
        end else begin
          s_nxt.abd_edges = s_r.abd_edges + 3'h1;
        end
      end
    end
    s_nxt.rx_prev = rx_bit;

    // Wake from sleep on a start edge
    if (s_r.mode[M_EN] && s_r.mode[M_WAKE] && sleep_mode) begin
      if (s_r.rx_prev && !rx_bit) begin
        s_nxt.wake_irq = 1'b1;
        s_nxt.wake_armed = 1'b1;
      end else if (s_r.wake_armed && !s_r.rx_prev && rx_bit) begin
        s_nxt.mode[M_WAKE] = 1'b0;
        s_nxt.wake_armed = 1'b0;
      end
    end

    // Software writes land last, so a write beats a hardware clear
    if (wr_en) begin
      case (addr)
        ADDR_MODE: s_nxt.mode = wdata & MODE_WMASK;
        ADDR_STAT: s_nxt.stat = wdata & STAT_WMASK;
        ADDR_DIV: begin
          s_nxt.div = wdata;
          s_nxt.div_wr = 1'b1;
        end
        default: s_nxt.div_wr = s_nxt.div_wr;
      endcase
    end
    if (s_r.stat[S_TXEN] && !s_nxt.stat[S_TXEN]) begin
      s_nxt.tx_cnt = 3'h0;
      s_nxt.tx_rd = 2'h0;
      s_nxt.tx_wr = 2'h0;
      s_nxt.tx_st = TX_IDLE;
      s_nxt.tx_brk = 1'b0;
      s_nxt.tx_irq = 1'b0;
    end

    // Read data stand for one cycle only
    if (rd_en) begin
      case (addr)
        ADDR_MODE: s_nxt.rdata = s_r.mode;
        ADDR_STAT: begin
          s_nxt.rdata = s_r.stat;
          s_nxt.rdata[S_TXBF] = (s_r.tx_cnt == FIFO_DEPTH);
          s_nxt.rdata[S_SHIFTER_EMPTY_FLAG] = (s_r.tx_st == TX_IDLE) &&
            (s_r.tx_cnt == 3'h0);
          s_nxt.rdata[S_RIDLE] = (s_r.rx_st == RX_IDLE);
          s_nxt.rdata[S_RXDA] = (s_r.rx_cnt != 3'h0);
        end
        ADDR_RXD: s_nxt.rdata = {7'h00, s_r.rxq[s_r.rx_rd]};
        ADDR_DIV: s_nxt.rdata = s_r.div;
        default: s_nxt.rdata = 16'h0000;
      endcase
    end

    // Pin drive
    s_nxt.tx_o = (ir_act ? (!tx_line && s_r.tx_st == TX_SHIFT &&
      s_r.tx_sub < IR_PULSE) : tx_line) ^ s_r.stat[S_TXINV];
    s_nxt.tx_oe = s_r.mode[M_EN] && s_r.stat[S_TXEN];
    s_nxt.rts_oe = s_r.mode[M_EN] && (s_r.mode[M_USE +: 2] == USE_RTS ||
      s_r.mode[M_USE +: 2] == USE_FLOW);
    // Simplex asserts while sending; flow control while room remains
    s_nxt.rts_n = s_r.mode[M_REQUEST_PIN_MODE_BIT] ?
      !(s_r.tx_st == TX_SHIFT || s_r.tx_cnt != 3'h0) :
      (s_r.rx_cnt == FIFO_DEPTH);
    s_nxt.bclk_oe = s_r.mode[M_EN] &&
      s_r.mode[M_USE +: 2] == USE_BCLK;
    s_nxt.bclk_o = bclk;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.mode <= MODE_RST;
      s_r.stat <= STAT_RST;
      s_r.div <= DIV_RST;
      s_r.tx_st <= TX_IDLE;
      s_r.rx_st <= RX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign serial_out_pin_o = s_r.tx_o;
  assign serial_out_pin_oe = s_r.tx_oe;
  assign request_to_send_pin_n_o = s_r.rts_n;
  assign request_to_send_pin_oe = s_r.rts_oe;
  assign baud_clock_out_pin_o = s_r.bclk_o;
  assign baud_clock_out_pin_oe = s_r.bclk_oe;
  assign tx_irq = s_r.tx_irq;
  assign rx_irq = s_r.rx_irq;
  assign wake_irq = s_r.wake_irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence wake_fall_seq;
    s_r.mode[M_EN] && s_r.mode[M_WAKE] && sleep_mode &&
      s_r.rx_prev && !rx_bit;
  endsequence

  sequence wake_rise_seq;
    s_r.mode[M_EN] && s_r.mode[M_WAKE] && sleep_mode &&
      s_r.wake_armed && !s_r.rx_prev && rx_bit && !wr_en;
  endsequence

  a_full_flag:
  assert property (rd_en && addr == ADDR_STAT |=>
    rdata[S_TXBF] == ($past(s_r.tx_cnt) == 3'h4))
    else $error("buffer full flag wrong");
  a_shifter_empty:
  assert property (rd_en && addr == ADDR_STAT |=>
    rdata[S_SHIFTER_EMPTY_FLAG] == ($past(s_r.tx_cnt) == 3'h0 &&
    $past(s_r.tx_st) == TX_IDLE))
    else $error("shifter empty flag wrong");
  a_pins_released:
  assert property (!s_r.mode[M_EN] |=> !serial_out_pin_oe &&
    !request_to_send_pin_oe && !baud_clock_out_pin_oe)
    else $error("pins driven while disabled");
  a_txen_abort:
  assert property (s_r.stat[S_TXEN] && wr_en && addr == ADDR_STAT &&
    !wdata[S_TXEN] |=> s_r.tx_cnt == 3'h0 && s_r.tx_st == TX_IDLE
    ##1 !serial_out_pin_oe)
    else $error("transmit not aborted");
  a_break_clear:
  assert property (tx_done && s_r.tx_brk && !wr_en |=> !s_r.stat[S_BRK])
    else $error("break bit not cleared");
  a_rate_done:
  assert property (abd_fin && !wr_en |=> !s_r.mode[M_AUTO_RATE_ENABLE] &&
    s_r.div_wr ##1 !s_r.div_wr)
    else $error("auto rate not finished");
  a_wake_event:
  assert property (wake_fall_seq |=> wake_irq ##1 !wake_irq)
    else $error("wake interrupt missing");
  a_wake_clear:
  assert property (wake_rise_seq |=> !s_r.mode[M_WAKE])
    else $error("wake bit not cleared");
  a_tx_irq_any:
  assert property (tx_load && {s_r.stat[S_TXIS1], s_r.stat[S_TXIS0]} ==
    TXI_ANY && !wr_en |=> tx_irq)
    else $error("transmit interrupt missing");
  a_rx_irq_four:
  assert property (rx_push && s_r.stat[S_RXIS +: 2] == RXI_4 &&
    s_r.rx_cnt != 3'h3 && !rx_pop |=> !rx_irq)
    else $error("receive interrupt too early");
  a_ir_gated:
  assert property (s_r.mode[M_HIGH_SPEED_SELECT] && s_r.tx_st == TX_IDLE
    [*2] |=> serial_out_pin_o == !$past(s_r.stat[S_TXINV]))
    else $error("codec active in fast mode");
  a_loop_path:
  assert property (s_r.mode[M_LPBK] && !s_r.mode[M_AUTO_RATE_ENABLE] && run &&
    tick && s_r.rx_st == RX_IDLE && !tx_line |=> s_r.rx_st == RX_START)
    else $error("loopback path broken");
  a_bclk_usage:
  assert property (s_r.mode[M_USE +: 2] != USE_BCLK |=>
    !baud_clock_out_pin_oe)
    else $error("clock pin driven");
endmodule

// >>> core/uart_cfg_pkg.sv
package uart_cfg_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_TXD = 4'h2;
  localparam logic [3:0] ADDR_RXD = 4'h3;
  localparam logic [3:0] ADDR_DIV = 4'h4;
  localparam logic [15:0] MODE_WMASK = 16'hbbff;
  localparam logic [15:0] STAT_WMASK = 16'hecc0;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] STAT_RST = 16'h0000;
  localparam logic [15:0] DIV_RST = 16'h0000;

  // ==========================================================
  // Mode register fields
  localparam int M_EN = 15;
  localparam int M_SIDL = 13;
  localparam int M_INFRARED_CODEC_ENABLE = 12;
  localparam int M_REQUEST_PIN_MODE_BIT = 11;
  localparam int M_USE = 8;
  localparam int M_WAKE = 7;
  localparam int M_LPBK = 6;
  localparam int M_AUTO_RATE_ENABLE = 5;
  localparam int M_RECEIVE_POLARITY_BIT = 4;
  localparam int M_HIGH_SPEED_SELECT = 3;
  localparam int M_PD = 1;
  localparam int M_STOP_BIT_SELECT = 0;

  // ==========================================================
  // Status register fields
  localparam int S_TXIS1 = 15;
  localparam int S_TXINV = 14;
  localparam int S_TXIS0 = 13;
  localparam int S_BRK = 11;
  localparam int S_TXEN = 10;
  localparam int S_TXBF = 9;
  localparam int S_SHIFTER_EMPTY_FLAG = 8;
  localparam int S_RXIS = 6;
  localparam int S_RIDLE = 4;
  localparam int S_RXDA = 0;

  // ==========================================================
  // Encodings and counts
  localparam logic [1:0] USE_TXRX = 2'h0;
  localparam logic [1:0] USE_RTS = 2'h1;
  localparam logic [1:0] USE_FLOW = 2'h2;
  localparam logic [1:0] USE_BCLK = 2'h3;
  localparam logic [1:0] PD_8N = 2'h0;
  localparam logic [1:0] PD_8E = 2'h1;
  localparam logic [1:0] PD_8O = 2'h2;
  localparam logic [1:0] PD_9N = 2'h3;
  localparam logic [1:0] TXI_ANY = 2'h0;
  localparam logic [1:0] TXI_DONE = 2'h1;
  localparam logic [1:0] TXI_EMPTY = 2'h2;
  localparam logic [1:0] RXI_3 = 2'h2;
  localparam logic [1:0] RXI_4 = 2'h3;
  localparam logic [2:0] FIFO_DEPTH = 3'h4;
  localparam logic [3:0] OS_LAST_STD = 4'hf;
  localparam logic [3:0] OS_LAST_HS = 4'h3;
  localparam logic [3:0] IR_PULSE = 4'h3;
  localparam logic [3:0] BRK_BITS = 4'he;
  localparam logic [2:0] SYNC_EDGES = 3'h5;
  localparam int ABD_SH_STD = 7;
  localparam int ABD_SH_HS = 5;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;

  // Last oversample tick index of a bit period
  function automatic logic [3:0] os_last(input logic hs);
    return hs ? OS_LAST_HS : OS_LAST_STD;
  endfunction

  // Frame, LSB first, with its bit count on top
  function automatic logic [18:0] build_frame(input logic [8:0] d,
    input logic [1:0] pd, input logic two, input logic brk);
    logic [14:0] b;
    logic [3:0] n;
    b = {6'h3f, d[7:0], 1'b0};
    n = 4'ha;
    if (brk) begin
      b = {2'h3, 13'h0000};
      n = BRK_BITS;
    end else if (pd == PD_9N) begin
      b = {5'h1f, d, 1'b0};
      n = 4'hb;
    end else if (pd != PD_8N) begin
      b = {5'h1f, (pd == PD_8O) ? ~^d[7:0] : ^d[7:0], d[7:0], 1'b0};
      n = 4'hb;
    end
    return {n + {3'h0, two}, b};
  endfunction
endpackage

// >>> core/baud_tick_gen.sv
`timescale 1ns/1ps
module baud_tick_gen
  import uart_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic [15:0] divisor,
  // Oversample tick and clock out
  output logic tick,
  output logic clk_out
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
    logic clk_out;
  } baud_state_t;

  baud_state_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    // A new divisor restarts the period at once
    if (restart || !run) begin
      s_nxt.cnt = 16'h0000;
    end else if (s_r.cnt >= divisor) begin
      s_nxt.cnt = 16'h0000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
    s_nxt.clk_out = run && (s_nxt.cnt <= (divisor >> 1));
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
  assign clk_out = s_r.clk_out;
endmodule

// >>> tb/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
  // Clock
  input wire logic clk,
  // Serial lines
  input wire logic line_in,
  output logic line_out
);
  // ==========================================================
  // Sender
  // Line rests at its high idle level between frames
  initial line_out = 1'b1;

  task automatic send(input logic [15:0] f, input int n, input int bpc);
    for (int i = 0; i < n; i++) begin
      line_out <= f[i];
      repeat (bpc) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask

  // ==========================================================
  // Receiver
  // Samples mid bit; unused high bits stay 1, all x if no start bit
  task automatic grab(input int n, input int bpc, output logic [15:0] f);
    int w;
    f = 16'hffff;
    w = 0;
    while (line_in !== 1'b0 && w < 3000) begin
      @(posedge clk);
      #1 w++;
    end
    if (w == 3000) begin
      f = 16'hxxxx;
    end else begin
      repeat (bpc / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
        #1 f[i] = line_in;
        repeat (bpc) @(posedge clk);
      end
    end
  endtask
endmodule

// >>> tb/uart_mode_status_control_test.sv
`timescale 1ns/1ps
module uart_mode_status_control_test
  import uart_cfg_pkg::*;
;
  logic clk, reset_n, wr_en, rd_en, idle_mode, sleep_mode, cts_n, rxl;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, got, f;
  logic [8:0] d;
  logic [7:0] rb [3];
  logic [1:0] pd;
  logic two, hs;
  logic txo, txoe, rtso, rtsoe, bco, bcoe, tx_irq, rx_irq, wake_irq;
  int err_count = 0, comparisons = 0, txn = 0, rxn = 0, wkn = 0;
  int seed, bpc, n0;

  uart_mode_status_control DUT (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .idle_mode(idle_mode), .sleep_mode(sleep_mode),
    .serial_in_pin(rxl), .serial_out_pin_o(txo),
    .serial_out_pin_oe(txoe), .clear_to_send_pin_n(cts_n),
    .request_to_send_pin_n_o(rtso), .request_to_send_pin_oe(rtsoe),
    .baud_clock_out_pin_o(bco), .baud_clock_out_pin_oe(bcoe),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .wake_irq(wake_irq));

  serial_peer peer (.clk(clk), .line_in(txo), .line_out(rxl));

  // ==========================================================
  // Clock, event counters and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    txn <= txn + int'(tx_irq === 1'b1);
    rxn <= rxn + int'(rx_irq === 1'b1);
    wkn <= wkn + int'(wake_irq === 1'b1);
  end

  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  // ==========================================================
  // Bus tasks and checks
  // Strobe drops for a cycle between accesses to keep one driver a step
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic give_verdict();
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic int fbits(input logic [1:0] p, input logic t);
    return 10 + int'(p != 2'h0) + int'(t);
  endfunction

  // Expected line bits, LSB first, idle ones above the stop bits
  function automatic logic [15:0] fexp(input logic [8:0] v,
    input logic [1:0] p);
    logic [15:0] e;
    e = {7'h7f, v[7:0], 1'b0};
    if (p == 2'h3) e[9] = v[8];
    if (p == 2'h1) e[9] = ^v[7:0];
    if (p == 2'h2) e[9] = ~^v[7:0];
    return e;
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h35bc;
    reset_n = 1'b0;
    {wr_en, rd_en, idle_mode, sleep_mode, cts_n} = 5'h00;
    addr = 4'h0;
    wdata = 16'h0000;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk({13'h0, txoe, rtsoe, bcoe}, 16'h0000);
    rd(ADDR_MODE, got);
    chk(got, MODE_RST);
    rd(ADDR_STAT, got);
    chk(got, 16'h0110);
    rd(4'hf, got);
    chk(got, 16'h0000);
    // Auto-rate left out here: it could clear before the read
    wr(ADDR_MODE, 16'hffdf);
    rd(ADDR_MODE, got);
    chk(got, 16'hbbdf);
    wr(ADDR_MODE, 16'h0000);
    wr(ADDR_STAT, 16'h12ff);
    rd(ADDR_STAT, got);
    chk(got, 16'h01d0);
    for (int u = 0; u < 4; u++) begin
      wr(ADDR_MODE, 16'h8000 | 16'(u << 8));
      repeat (2) @(posedge clk);
      #1 chk({14'h0, rtsoe, bcoe}, {14'h0, u == 1 || u == 2, u == 3});
    end
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_MODE, {3'h4, p[1], 12'h000});
      wr(ADDR_STAT, {1'b0, p[0], 4'h1, 10'h000});
      repeat (3) @(posedge clk);
      #1 chk({14'h0, txoe, txo}, {15'h1, ~(p[1] ^ p[0])});
    end
    wr(ADDR_STAT, 16'h0000);
    repeat (2) @(posedge clk);
    chk({15'h0, txoe}, 16'h0000);
    wr(ADDR_DIV, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      pd = k[1:0];
      two = k[2];
      hs = (k != 6);
      bpc = hs ? 4 : 16;
      d = 9'($random(seed));
      wr(ADDR_MODE, {12'h800, hs, pd, two});
      wr(ADDR_STAT, 16'h0400);
      wr(ADDR_TXD, {7'h00, d});
      peer.grab(fbits(pd, two), bpc, f);
      chk(f, fexp(d, pd));
      if ($isunknown(f)) give_verdict();
      repeat (bpc) @(posedge clk);
    end
    wr(ADDR_MODE, 16'h8008);
    for (int m = 0; m < 3; m++) begin
      n0 = txn;
      wr(ADDR_STAT, {m[1], 1'b0, m[0], 3'h1, 10'h000});
      wr(ADDR_TXD, 16'h00a5);
      wr(ADDR_TXD, 16'h005a);
      repeat (120) @(posedge clk);
      chk(16'(txn - n0), (m == 1) ? 16'h0001 : 16'h0002);
    end
    wr(ADDR_STAT, 16'h0c00);
    wr(ADDR_TXD, 16'h0000);
    peer.grab(14, 4, f);
    chk(f, 16'he000);
    repeat (8) @(posedge clk);
    rd(ADDR_STAT, got);
    chk(got, 16'h0510);
    // Slow rate so the shifter stays busy while the buffer fills
    wr(ADDR_DIV, 16'h0003);
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_TXD, 16'(k));
    end
    rd(ADDR_STAT, got);
    chk(got, 16'h0610);
    wr(ADDR_STAT, 16'h0000);
    repeat (2) @(posedge clk);
    rd(ADDR_STAT, got);
    chk(got, 16'h0110);
    chk({15'h0, txoe}, 16'h0000);
    wr(ADDR_DIV, 16'h0000);
    wr(ADDR_MODE, 16'ha008);
    wr(ADDR_STAT, 16'h0400);
    idle_mode <= 1'b1;
    @(posedge clk);
    wr(ADDR_TXD, 16'h0033);
    repeat (40) @(posedge clk);
    chk({15'h0, txo}, 16'h0001);
    rd(ADDR_STAT, got);
    chk(got, 16'h0410);
    idle_mode <= 1'b0;
    peer.grab(10, 4, f);
    chk(f, fexp(9'h033, 2'h0));
    repeat (8) @(posedge clk);
    wr(ADDR_STAT, 16'h0080);
    n0 = rxn;
    for (int k = 0; k < 3; k++) begin
      rb[k] = 8'($random(seed));
      peer.send({7'h7f, rb[k], 1'b0}, 10, 4);
      repeat (4) @(posedge clk);
      chk(16'(rxn - n0), 16'(k == 2));
    end
    for (int k = 0; k < 3; k++) begin
      rd(ADDR_RXD, got);
      chk(got, {8'h00, rb[k]});
    end
    wr(ADDR_MODE, 16'h8048);
    wr(ADDR_STAT, 16'h0400);
    n0 = rxn;
    wr(ADDR_TXD, 16'h00c3);
    repeat (60) @(posedge clk);
    chk(16'(rxn - n0), 16'h0001);
    rd(ADDR_RXD, got);
    chk(got, 16'h00c3);
    wr(ADDR_MODE, 16'h8028);
    peer.send(16'hfeaa, 10, 8);
    repeat (8) @(posedge clk);
    rd(ADDR_MODE, got);
    chk(got, 16'h8008);
    sleep_mode <= 1'b1;
    wr(ADDR_MODE, 16'h8080);
    n0 = wkn;
    peer.send(16'h0000, 1, 8);
    repeat (4) @(posedge clk);
    sleep_mode <= 1'b0;
    chk(16'(wkn - n0), 16'h0001);
    rd(ADDR_MODE, got);
    chk(got, 16'h8000);
    give_verdict();
  end
endmodule
